// ===== design/ahpi_pkg.sv
/*
 * ahpi_pkg: constants shared by the host pin interface of the storage port.
 * assumes a 40 MHz core clock; all timing counts are derived from it.
 */
package ahpi_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int PIO0_SETUP_NS = 70;
    localparam int PIO0_ACTIVE_NS = 290;
    localparam int PIO0_RECOVERY_NS = 240;
    localparam int PIO_SETUP_CYC = (PIO0_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PIO_ACTIVE_CYC = (PIO0_ACTIVE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PIO_RECOV_CYC = (PIO0_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int UDMA_HALF_NS = 120;
    localparam int UDMA_HALF_CYC = (UDMA_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // pin widths and chip-select codes (active-low selects)
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int FIFO_DEPTH = 32;
    localparam logic [1:0] CS_NONE = 2'h3;
    localparam logic [1:0] CS_CMD_BLOCK = 2'h2;
    localparam logic [1:0] CS_CTRL_BLOCK = 2'h1;

    // ------------------------------------------------------------
    // transfer kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AHPI_XFER_PIO = 2'b00,
        AHPI_XFER_MDMA = 2'b01,
        AHPI_XFER_UDMA = 2'b10
    } ahpi_xfer_t;

endpackage : ahpi_pkg

// ===== design/ahpi_fifo.sv
/*
 * ahpi_fifo: synchronous valid/ready fifo for the data path.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module ahpi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wr_d = push ? wr_q + AW'(1) : wr_q;
        rd_d = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush)
        begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : ahpi_fifo
`default_nettype wire

// ===== design/ahpi_host_port.sv
/*
 * ahpi_host_port: host-side pins of a parallel storage port (task-file PIO,
 * multiword dma, ultra-dma) with a 32-word data fifo toward the user side.
 * assumes the attached drive obeys the pin protocol; user requests are on
 * core_clk; drive pins are asynchronous; request, ready and irq pass a 3-flop filter, the data bus is sampled twice.
 */
`timescale 1ns/1ps
`default_nettype none
module ahpi_host_port #(
    parameter int DEPTH = ahpi_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    // user side
    input wire logic pio_req,
    input wire logic pio_write,
    input wire logic pio_ctrl_block,
    input wire logic [2:0] pio_addr,
    input wire logic [15:0] pio_wdata,
    output logic pio_done,
    output logic [15:0] pio_rdata,
    input wire logic dma_enable,
    input wire logic dma_dir_in,
    input wire logic dma_ultra,
    input wire logic card_ide_mode_select,
    input wire logic reset_active_high,
    input wire logic device_reset_req,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [15:0] wr_data,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [15:0] rd_data,
    output logic irq_out,
    // drive pins
    output logic [1:0] host_chip_selects,
    output logic host_addr_bit0,
    output logic host_addr_bit1,
    output logic host_addr_bit2,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe,
    input wire logic dma_request_in,
    output logic dma_ack_out,
    input wire logic device_ready_in,
    output logic host_read_strobe_out,
    output logic host_write_strobe_out,
    input wire logic device_irq_in,
    output logic device_reset_out,
    output logic buffer_direction_out
);
    localparam int CW = ahpi_pkg::CNT_W;

    // ------------------------------------------------------------
    // pin input filters: change counts once flops 2 and 3 agree
    // ------------------------------------------------------------
    logic [2:0] rq_s, rdy_s, irq_s;
    logic dmarq_q, dmarq_d, rdy_q, rdy_d, irqf_q, irqf_d;
    logic [15:0] din_a_q, din_b_q;

    always_comb
    begin
        dmarq_d = (rq_s[1] == rq_s[2]) ? rq_s[2] : dmarq_q;
        rdy_d = (rdy_s[1] == rdy_s[2]) ? rdy_s[2] : rdy_q;
        irqf_d = (irq_s[1] == irq_s[2]) ? irq_s[2] : irqf_q;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rq_s <= '0;
            rdy_s <= 3'h7;
            irq_s <= '0;
            dmarq_q <= 1'b0;
            rdy_q <= 1'b1;
            irqf_q <= 1'b0;
            din_a_q <= '0;
            din_b_q <= '0;
        end
        else
        begin
            rq_s <= {rq_s[1:0], dma_request_in};
            rdy_s <= {rdy_s[1:0], device_ready_in};
            irq_s <= {irq_s[1:0], device_irq_in};
            dmarq_q <= dmarq_d;
            rdy_q <= rdy_d;
            irqf_q <= irqf_d;
            // data is sampled twice; it is quiet by the time a strobe edge uses it
            din_a_q <= host_data_bus_in;
            din_b_q <= din_a_q;
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_RECOV = 3'b011,
        ST_UDMA = 3'b100,
        ST_STOP = 3'b101
    } ahpi_state_t;

    ahpi_state_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic is_dma_q, is_dma_d, write_q, write_d, cap_q, cap_d, take_q, take_d;
    logic [1:0] cs_q, cs_d;
    logic [2:0] addr_q, addr_d;
    logic [15:0] dout_q, dout_d, rdat_q, rdat_d;
    logic oe_q, oe_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, ack_q, ack_d, dir_q, dir_d;
    logic done_q, done_d, rdy_prev_q, hstb_q, hstb_d;
    logic dma_allowed;

    // ------------------------------------------------------------
    // fifo between user and pins (one direction at a time)
    // ------------------------------------------------------------
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [15:0] f_in_data, f_out_data;
    logic fill_from_pins;

    assign fill_from_pins = dma_dir_in;
    assign f_in_valid = fill_from_pins ? cap_q : wr_valid;
    assign f_in_data = fill_from_pins ? din_b_q : wr_data;
    assign wr_ready = !fill_from_pins && f_in_ready;
    assign f_out_ready = fill_from_pins ? rd_ready : take_q;
    assign rd_valid = fill_from_pins && f_out_valid;
    assign rd_data = f_out_data;

    ahpi_fifo #(.WIDTH(ahpi_pkg::DATA_W), .DEPTH(DEPTH)) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .flush(st_q == ST_IDLE && !dma_enable),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    // a flash card in true-ide mode has no dma wires
    assign dma_allowed = dma_enable && !card_ide_mode_select;

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q - CW'(1);
        is_dma_d = is_dma_q;
        write_d = write_q;
        cs_d = cs_q;
        addr_d = addr_q;
        dout_d = dout_q;
        rdat_d = rdat_q;
        oe_d = 1'b0;
        rd_n_d = 1'b1;
        wr_n_d = 1'b1;
        ack_d = 1'b0;
        dir_d = 1'b0;
        done_d = 1'b0;
        cap_d = 1'b0;
        take_d = 1'b0;
        hstb_d = hstb_q;
        unique case (st_q)
            ST_IDLE:
            begin
                cs_d = ahpi_pkg::CS_NONE;
                cnt_d = CW'(ahpi_pkg::PIO_SETUP_CYC);
                if (dma_allowed && dmarq_q &&
                    (dma_dir_in ? f_in_ready : f_out_valid))
                begin
                    is_dma_d = 1'b1;
                    write_d = !dma_dir_in;
                    ack_d = 1'b1;
                    dir_d = !dma_dir_in;
                    hstb_d = 1'b1;
                    if (!dma_dir_in)
                    begin
                        dout_d = f_out_data;
                    end
                    st_d = dma_ultra ? ST_UDMA : ST_SETUP;
                    cnt_d = dma_ultra ? CW'(ahpi_pkg::UDMA_HALF_CYC)
                                      : CW'(ahpi_pkg::PIO_SETUP_CYC);
                end
                else if (pio_req)
                begin
                    is_dma_d = 1'b0;
                    write_d = pio_write;
                    cs_d = pio_ctrl_block ? ahpi_pkg::CS_CTRL_BLOCK
                                          : ahpi_pkg::CS_CMD_BLOCK;
                    addr_d = pio_addr;
                    dout_d = pio_wdata;
                    dir_d = pio_write;
                    st_d = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                ack_d = is_dma_q;
                dir_d = write_q;
                oe_d = write_q;
                if (cnt_q == CW'(1))
                begin
                    st_d = ST_ACTIVE;
                    cnt_d = CW'(ahpi_pkg::PIO_ACTIVE_CYC);
                end
            end
            ST_ACTIVE:
            begin
                ack_d = is_dma_q;
                dir_d = write_q;
                oe_d = write_q;
                rd_n_d = write_q;
                wr_n_d = !write_q;
                if (!rdy_q && !is_dma_q)
                begin
                    cnt_d = cnt_q;
                end
                if (cnt_q == CW'(1) && (rdy_q || is_dma_q))
                begin
                    st_d = ST_RECOV;
                    cnt_d = CW'(ahpi_pkg::PIO_RECOV_CYC);
                    rdat_d = din_b_q;
                    cap_d = is_dma_q && !write_q;
                    take_d = is_dma_q && write_q;
                    done_d = !is_dma_q;
                end
            end
            ST_RECOV:
            begin
                ack_d = is_dma_q;
                if (cnt_q == CW'(1))
                begin
                    st_d = ST_IDLE;
                    cs_d = ahpi_pkg::CS_NONE;
                end
            end
            ST_UDMA:
            begin
                ack_d = 1'b1;
                dir_d = write_q;
                oe_d = write_q;
                cnt_d = cnt_q;
                if (write_q)
                begin
                    // pause while the drive holds its ready low
                    if (rdy_q && f_out_valid)
                    begin
                        cnt_d = cnt_q - CW'(1);
                        if (cnt_q == CW'(1))
                        begin
                            hstb_d = !hstb_q;
                            take_d = 1'b1;
                            dout_d = f_out_data;
                            cnt_d = CW'(ahpi_pkg::UDMA_HALF_CYC);
                        end
                    end
                    rd_n_d = hstb_q;
                end
                else
                begin
                    rd_n_d = !f_in_ready;
                    cap_d = (rdy_q != rdy_prev_q) && f_in_ready;
                end
                if (!dmarq_q || !dma_allowed)
                begin
                    st_d = ST_STOP;
                    cnt_d = CW'(ahpi_pkg::UDMA_HALF_CYC);
                end
            end
            ST_STOP:
            begin
                ack_d = 1'b1;
                wr_n_d = 1'b0;
                rd_n_d = write_q ? hstb_q : 1'b1;
                if (cnt_q == CW'(1))
                begin
                    st_d = ST_IDLE;
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
        if (is_dma_q && st_q != ST_IDLE)
        begin
            cs_d = ahpi_pkg::CS_NONE;
        end
        if (st_d == ST_IDLE)
        begin
            ack_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            is_dma_q <= 1'b0;
            write_q <= 1'b0;
            cs_q <= ahpi_pkg::CS_NONE;
            addr_q <= '0;
            dout_q <= '0;
            rdat_q <= '0;
            oe_q <= 1'b0;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ack_q <= 1'b0;
            dir_q <= 1'b0;
            done_q <= 1'b0;
            cap_q <= 1'b0;
            take_q <= 1'b0;
            hstb_q <= 1'b1;
            rdy_prev_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            is_dma_q <= is_dma_d;
            write_q <= write_d;
            cs_q <= cs_d;
            addr_q <= addr_d;
            dout_q <= dout_d;
            rdat_q <= rdat_d;
            oe_q <= oe_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            ack_q <= ack_d;
            dir_q <= dir_d;
            done_q <= done_d;
            cap_q <= cap_d;
            take_q <= take_d;
            hstb_q <= hstb_d;
            rdy_prev_q <= rdy_q;
        end
    end

    // ------------------------------------------------------------
    // reset pin and interrupt
    // ------------------------------------------------------------
    logic drst_q, drst_d, irq_q;

    assign drst_d = device_reset_req ~^ reset_active_high;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            drst_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            drst_q <= drst_d;
            irq_q <= irqf_q;
        end
    end

    assign host_chip_selects = cs_q;
    assign host_addr_bit0 = addr_q[0];
    assign host_addr_bit1 = addr_q[1];
    assign host_addr_bit2 = addr_q[2];
    assign host_data_bus_out = dout_q;
    assign host_data_bus_oe = oe_q;
    assign dma_ack_out = ack_q;
    assign host_read_strobe_out = rd_n_q;
    assign host_write_strobe_out = wr_n_q;
    assign buffer_direction_out = dir_q;
    assign device_reset_out = drst_q;
    assign irq_out = irq_q;
    assign pio_done = done_q;
    assign pio_rdata = rdat_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_dma_start;
        st_q == ST_IDLE && st_d != ST_IDLE && is_dma_d;
    endsequence

    property p_cs_idle_dma;
        @(posedge core_clk) disable iff (reset)
        dma_ack_out |-> host_chip_selects == ahpi_pkg::CS_NONE;
    endproperty
    a_cs_idle_dma: assert property (p_cs_idle_dma) else $error("chip select during dma");

    property p_ack_needs_burst;
        @(posedge core_clk) disable iff (reset)
        s_dma_start |=> dma_ack_out;
    endproperty
    a_ack_needs_burst: assert property (p_ack_needs_burst) else $error("no dma ack");

    property p_ack_idle;
        @(posedge core_clk) disable iff (reset)
        (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |-> !dma_ack_out;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack while idle");

    property p_oe_only_write;
        @(posedge core_clk) disable iff (reset)
        host_data_bus_oe |-> write_q && buffer_direction_out;
    endproperty
    a_oe_only_write: assert property (p_oe_only_write) else $error("bus driven on read");

    property p_pio_stretch;
        @(posedge core_clk) disable iff (reset)
        (st_q == ST_ACTIVE && !is_dma_q && !rdy_q) |=> st_q == ST_ACTIVE;
    endproperty
    a_pio_stretch: assert property (p_pio_stretch) else $error("strobe not stretched");

    property p_no_dma_card;
        @(posedge core_clk) disable iff (reset)
        card_ide_mode_select && st_q == ST_IDLE |=> !dma_ack_out;
    endproperty
    a_no_dma_card: assert property (p_no_dma_card) else $error("dma on flash card");

    property p_cs_select;
        @(posedge core_clk) disable iff (reset)
        (st_q == ST_IDLE && pio_req && !is_dma_d && st_d == ST_SETUP)
        |=> host_chip_selects == ($past(pio_ctrl_block) ? ahpi_pkg::CS_CTRL_BLOCK
                                                       : ahpi_pkg::CS_CMD_BLOCK);
    endproperty
    a_cs_select: assert property (p_cs_select) else $error("wrong block select");

    property p_stop_ends;
        @(posedge core_clk) disable iff (reset)
        st_q == ST_STOP |=> !host_write_strobe_out;
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop not shown");

endmodule : ahpi_host_port
`default_nettype wire

// ===== verification/ahpi_drive_model.sv
/*
 * ahpi_drive_model: behavioural attached drive facing the host port pins.
 * assumes active-low selects and strobes, and host output enable high while driving.
 */
`timescale 1ns/1ps
`default_nettype none
module ahpi_drive_model (
    input wire logic core_clk,
    input wire logic [1:0] host_chip_selects,
    input wire logic [2:0] addr,
    input wire logic [15:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    input wire logic dma_ack_out,
    input wire logic host_read_strobe_out,
    input wire logic host_write_strobe_out,
    input wire logic [3:0] stall,
    input wire logic pause,
    input wire logic want_dma,
    input wire logic dir_in,
    output logic [15:0] host_data_bus_in,
    output logic dma_request_in,
    output logic device_ready_in
);
    logic [15:0] regs [16];
    logic [15:0] cap [64];
    int ncap = 0;
    logic [3:0] wait_q = 4'h0;
    logic rd_q = 1'b1;
    logic wr_q = 1'b1;
    logic [15:0] junk = 16'h5a5a;
    logic dstb = 1'b1;
    logic [15:0] dword = 16'ha000;
    logic [3:0] tick = 4'h0;
    logic burst_in;
    logic sel;
    logic drv;
    logic [3:0] idx;
    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign sel = host_chip_selects != 2'h3;
    assign idx = {~host_chip_selects[1], addr};
    // read data held one cycle past the strobe, then the bus floats to a moving pattern
    assign drv = sel && !(host_read_strobe_out && rd_q);
    assign burst_in = dir_in && dma_ack_out;
    assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out
                            : burst_in ? dword : drv ? regs[idx] : junk;
    assign dma_request_in = want_dma;
    // on a data-in burst the ready pin carries the drive's data strobe
    assign device_ready_in = burst_in ? dstb : wait_q == 4'h0 && !pause;
    always @(posedge core_clk)
    begin
        junk <= ~junk;
        rd_q <= host_read_strobe_out;
        wr_q <= host_write_strobe_out;
        if (sel && ((wr_q && !host_write_strobe_out) || (rd_q && !host_read_strobe_out)))
            wait_q <= stall;
        else if (wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
        // latched while the strobe is low: the host drops its enable as the strobe rises
        if (sel && !host_write_strobe_out)
            regs[idx] <= host_data_bus_in;
        if (burst_in && want_dma && !host_read_strobe_out)
        begin
            tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
            if (tick == 4'h9)
                {dstb, dword} <= {!dstb, dword + 16'h0001};
        end
        if (dma_ack_out && host_write_strobe_out && rd_q != host_read_strobe_out && ncap < 64)
        begin
            cap[ncap] <= host_data_bus_in;
            ncap <= ncap + 1;
        end
    end
endmodule : ahpi_drive_model
`default_nettype wire

// ===== verification/ahpi_host_port_tb.sv
/*
 * ahpi_host_port_tb: self-checking bench for the host port against the drive model.
 * assumes the design package is compiled first; inputs change on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module ahpi_host_port_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0, reset = 1'b1, pio_req = 1'b0, pio_write = 1'b0, pio_ctrl_block = 1'b0;
    logic [2:0] pio_addr = 3'h0;
    logic [15:0] pio_wdata = 16'h0000, wr_data = 16'h0000, pio_rdata, rd_data, bus_out, bus_in;
    logic dma_enable = 1'b0, dma_ultra = 1'b0, card_ide_mode_select = 1'b0, dma_dir_in = 1'b0;
    logic reset_active_high = 1'b1, device_reset_req = 1'b0, wr_valid = 1'b0;
    logic device_irq_in = 1'b0, pause = 1'b0, want_dma = 1'b0;
    logic [3:0] stall = 4'h0;
    logic pio_done, wr_ready, rd_valid, irq_out, oe, dma_request_in, dma_ack_out;
    logic device_ready_in, rd_n, wr_n, device_reset_out, buffer_direction_out, a0, a1, a2;
    logic [1:0] cs;
    int failures = 0;
    int n_compared = 0;

    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    ahpi_host_port dut_u (.core_clk(core_clk), .reset(reset), .pio_req(pio_req),
        .pio_write(pio_write), .pio_ctrl_block(pio_ctrl_block), .pio_addr(pio_addr),
        .pio_wdata(pio_wdata), .pio_done(pio_done), .pio_rdata(pio_rdata),
        .dma_enable(dma_enable), .dma_dir_in(dma_dir_in), .dma_ultra(dma_ultra),
        .card_ide_mode_select(card_ide_mode_select), .reset_active_high(reset_active_high),
        .device_reset_req(device_reset_req), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(1'b1), .rd_data(rd_data),
        .irq_out(irq_out), .host_chip_selects(cs), .host_addr_bit0(a0), .host_addr_bit1(a1),
        .host_addr_bit2(a2), .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
        .host_data_bus_oe(oe), .dma_request_in(dma_request_in), .dma_ack_out(dma_ack_out),
        .device_ready_in(device_ready_in), .host_read_strobe_out(rd_n),
        .host_write_strobe_out(wr_n), .device_irq_in(device_irq_in),
        .device_reset_out(device_reset_out), .buffer_direction_out(buffer_direction_out));

    ahpi_drive_model dm_u (.core_clk(core_clk), .host_chip_selects(cs), .addr({a2, a1, a0}),
        .host_data_bus_out(bus_out), .host_data_bus_oe(oe), .dma_ack_out(dma_ack_out),
        .host_read_strobe_out(rd_n), .host_write_strobe_out(wr_n), .stall(stall),
        .pause(pause), .want_dma(want_dma), .dir_in(dma_dir_in), .host_data_bus_in(bus_in),
        .dma_request_in(dma_request_in), .device_ready_in(device_ready_in));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic pio(input logic wr, input logic ctrl, input logic [2:0] a,
        input logic [15:0] d, input logic [3:0] st);
        int low;
        low = 0;
        stall = st;
        {pio_write, pio_ctrl_block, pio_addr, pio_wdata, pio_req} = {wr, ctrl, a, d, 1'b1};
        for (int i = 0; i < 200 && pio_done !== 1'b1; i++)
        begin
            @(negedge core_clk);
            if ((wr ? wr_n : rd_n) === 1'b0)
            begin
                low++;
                check({cs, a2, a1, a0, oe, buffer_direction_out}, {ctrl ? 2'h1 : 2'h2, a, wr, wr});
                if (wr)
                    check(bus_out, d);
            end
        end
        pio_req = 1'b0;
        check(pio_done, 1'b1);
        if (st == 4'h0)
            check(low, 12);
        else
            check(low > 12, 1'b1);
        if (!wr)
            check(pio_rdata, d);
        repeat (12) @(negedge core_clk);
        check({cs, oe}, 3'h6);
    endtask : pio

    // fill the fifo until refused, hold off under card mode, then drain it in one ultra burst
    task automatic udma_out();
        int n;
        int c0;
        logic bad;
        n = 0;
        c0 = 0;
        bad = 1'b0;
        {dma_enable, dma_ultra, card_ide_mode_select} = 3'h7;
        while (n < 40 && wr_ready === 1'b1)
        begin
            {wr_valid, wr_data} = {1'b1, 16'hc000 + 16'(n)};
            @(negedge core_clk);
            n++;
        end
        wr_valid = 1'b0;
        check(n, 32);
        want_dma = 1'b1;
        repeat (30) @(negedge core_clk) bad |= dma_ack_out;
        check({bad, wr_ready}, 2'h0);
        card_ide_mode_select = 1'b0;
        for (int i = 0; i < 600 && dm_u.ncap < 32; i++)
        begin
            @(negedge core_clk);
            bad |= dma_ack_out && cs !== 2'h3;
            pause = i >= 40 && i < 70;
            if (i == 50)
                c0 = dm_u.ncap;
            if (i == 69)
                check(dm_u.ncap, c0);
        end
        check({bad, dma_ack_out}, 2'h1);
        for (int k = 0; k < 32; k++)
            check(dm_u.cap[k], 16'hc000 + 16'(k));
        want_dma = 1'b0;
        for (int i = 0; i < 40 && wr_n !== 1'b0; i++)
            @(negedge core_clk);
        check(wr_n, 1'b0);
        for (int i = 0; i < 40 && dma_ack_out !== 1'b0; i++)
            @(negedge core_clk);
        check({dma_ack_out, oe, wr_ready}, 3'h1);
        dma_enable = 1'b0;
    endtask : udma_out

    // take eight words from the drive in one ultra data-in burst
    task automatic udma_in();
        int k;
        k = 0;
        {dma_dir_in, dma_enable, dma_ultra, want_dma} = 4'hf;
        for (int i = 0; i < 400 && k < 8; i++)
        begin
            @(negedge core_clk);
            if (rd_valid === 1'b1)
            begin
                check(rd_data, 16'ha001 + 16'(k));
                k++;
            end
        end
        want_dma = 1'b0;
        check(k, 8);
        for (int i = 0; i < 40 && dma_ack_out !== 1'b0; i++)
            @(negedge core_clk);
        check({dma_ack_out, rd_n, rd_valid}, 3'h2);
        {dma_dir_in, dma_enable} = 2'h0;
    endtask : udma_in

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        #500000;
        failures++;
        stop_test();
    end

    initial
    begin
        repeat (6) @(negedge core_clk);
        check({cs, rd_n, wr_n, oe, dma_ack_out}, 6'h3c);
        reset = 1'b0;
        @(negedge core_clk);
        pio(1'b1, 1'b0, 3'h5, 16'h1234, 4'h0);
        pio(1'b1, 1'b1, 3'h5, 16'hbeef, 4'h0);
        pio(1'b0, 1'b0, 3'h5, 16'h1234, 4'h9);
        pio(1'b0, 1'b1, 3'h5, 16'hbeef, 4'h0);
        device_irq_in = 1'b1;
        repeat (8) @(negedge core_clk);
        check(irq_out, 1'b1);
        device_irq_in = 1'b0;
        repeat (8) @(negedge core_clk);
        check(irq_out, 1'b0);
        for (int p = 0; p < 2; p++)
            for (int r = 0; r < 2; r++)
            begin
                {reset_active_high, device_reset_req} = {p[0], r[0]};
                repeat (4) @(negedge core_clk);
                check(device_reset_out, r[0] ? p[0] : !p[0]);
            end
        udma_out();
        udma_in();
        stop_test();
    end
endmodule : ahpi_host_port_tb
`default_nettype wire
